// ---- adc_conversion_control_tb.sv ----
// self-checking bench for the conversion controller
`include "conv_consts.svh"
module adc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, d;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, byp, tick, busy, done, irq, en, fc;
   logic [1:0] bresp, rresp, ref_sel, rs;
   logic [4:0] chan;
   logic [6:0] trig = 7'h0;
   logic [9:0] code = 10'h0, cur, core_result;
   logic [7:0] tk;
   logic [31:0] seed = 32'h379e;
   logic left = 1'b0;
   int miscompares = 0;
   int tests_run = 0;
   int k;
   logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h10, 8'h14};

   always #20 clk_i = ~clk_i;

   conv_ctrl #(.TRIG_W(7)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .trigger_i(trig), .core_result_i(core_result), .converter_enable_o(en), .reference_select_o(ref_sel),
      .channel_gain_select_o(chan), .gain_bypass_o(byp), .converter_tick_o(tick), .converting_o(busy),
      .first_conversion_o(fc), .conversion_done_o(done), .irq_o(irq));

   conv_core_model i_core (.clk_i(clk_i), .resetn_i(resetn_i), .converting_i(busy), .tick_i(tick),
      .done_i(done), .code_i(code), .core_result_o(core_result), .ticks_o(tk));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // high byte in [15:8], low byte in [7:0]
   function automatic logic [15:0] align(logic [9:0] c, logic l);
      return l ? {c, 6'h00} : {6'h00, c};
   endfunction

   function automatic logic [1:0] resp(logic [7:0] a);
      return (a <= 8'h10 && a[1:0] == 2'b00) ? `CONV_RESP_OKAY : `CONV_RESP_SLVERR;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic wrap_up();
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            chk("bresp", {30'h0, resp(a)}, {30'h0, bresp});
            break;
         end
      end
      if (n == 100) chk("write_answer", 1, 0);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      int n;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 8'hxx;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            chk("rresp", {30'h0, resp(a)}, {30'h0, rresp});
            chk("rdata_upper", 0, {rdata[31:8], 8'h0});
            v = rdata[7:0];
            break;
         end
      end
      if (n == 100) chk("read_answer", 1, 0);
   endtask

   task automatic start(input logic [7:0] ctl);
      code <= 10'(rnd());
      wr(`CONV_OFS_CTRL_STAT, ctl);
      rd(`CONV_OFS_CTRL_STAT, d);
      chk("busy_bit", 1, d[6]);
   endtask

   task automatic finish(input int n);
      int i;
      for (i = 0; i < 3000 && done !== 1'b1; i++)
         @(posedge clk_i);
      chk("done_seen", 1, done);
      @(posedge clk_i);
      chk("tick_count", n, tk);
   endtask

   task automatic result(input logic [9:0] c);
      rd(`CONV_OFS_RES_LOW, d);
      chk("res_low", align(c, left) & 16'h00ff, d);
      rd(`CONV_OFS_RES_HIGH, d);
      chk("res_high", align(c, left) >> 8, d);
   endtask

   task automatic quiet(input int cyc);
      k = 0;
      repeat (cyc)
      begin
         @(posedge clk_i);
         k += busy;
      end
   endtask

   initial
   begin
      #2000000;
      miscompares++;
      wrap_up();
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      foreach (ofs[j])
      begin
         rd(ofs[j], d);
         chk("reset_value", 0, d);
      end
      wr(8'h14, 8'hff);
      rs = 2'(rnd());
      wr(`CONV_OFS_MUX_SEL, {rs, 1'b0, 5'h03});
      @(posedge clk_i);
      chk("ref_disabled", 0, ref_sel);
      chk("chan_disabled", 0, chan);
      wr(`CONV_OFS_CTRL_STAT, 8'h80);
      for (int c = 0; c < 32; c++)
      begin
         rs = 2'(rnd());
         wr(`CONV_OFS_MUX_SEL, {rs, 1'b0, 5'(c)});
         @(posedge clk_i);
         chk("ref_applied", rs, ref_sel);
         chk("chan_applied", c, chan);
         chk("bypass", c <= 7 || c >= 30, byp);
      end
      wr(`CONV_OFS_MUX_SEL, 8'h02);
      start(8'hc0);
      chk("first_flag", 1, fc);
      wr(`CONV_OFS_MUX_SEL, 8'h05);
      chk("chan_held", 2, chan);
      finish(25);
      cur = code;
      repeat (3) @(posedge clk_i);
      chk("chan_after", 5, chan);
      rd(`CONV_OFS_CTRL_STAT, d);
      chk("flag_set", 1, d[4]);
      chk("start_clear", 0, d[6]);
      result(cur);
      left = 1'b1;
      wr(`CONV_OFS_MUX_SEL, 8'h25);
      result(cur);
      wr(`CONV_OFS_CTRL_STAT, 8'h88);
      chk("irq_on", 1, irq);
      wr(`CONV_OFS_CTRL_STAT, 8'h98);
      chk("irq_off", 0, irq);
      rd(`CONV_OFS_RES_LOW, d);
      start(8'hc8);
      chk("first_flag", 0, fc);
      finish(13);
      @(posedge clk_i);
      chk("irq_discard", 1, irq);
      result(cur);
      wr(`CONV_OFS_SPECIAL, 8'h00);
      start(8'he0);
      finish(13);
      wr(`CONV_OFS_MUX_SEL, 8'h24);
      rd(`CONV_OFS_CTRL_STAT, d);
      chk("busy_free", 1, d[6]);
      finish(13);
      chk("chan_free", 4, chan);
      wr(`CONV_OFS_CTRL_STAT, 8'h00);
      quiet(30);
      chk("off_busy", 0, k);
      chk("off_enable", 0, en);
      wr(`CONV_OFS_SPECIAL, 8'h40);
      wr(`CONV_OFS_CTRL_STAT, 8'ha0);
      trig <= 7'h02;
      finish(25);
      result(code);
      trig <= 7'h00;
      repeat (4) @(posedge clk_i);
      trig <= 7'h02;
      repeat (14) @(posedge clk_i);
      trig <= 7'h00;
      repeat (4) @(posedge clk_i);
      trig <= 7'h02;
      finish(13);
      quiet(40);
      chk("edge_ignored", 0, k);
      start(8'he0);
      finish(13);
      result(code);
      wrap_up();
   end
endmodule

// ---- conv_consts.svh ----
// register map, field positions, reset values and timing counts of the conversion controller
`ifndef CONV_CONSTS_SVH
`define CONV_CONSTS_SVH

`define CONV_OFS_MUX_SEL 8'h00
`define CONV_OFS_CTRL_STAT 8'h04
`define CONV_OFS_RES_LOW 8'h08
`define CONV_OFS_RES_HIGH 8'h0c
`define CONV_OFS_SPECIAL 8'h10

`define CONV_MUX_REF_POS 6
`define CONV_MUX_LEFT_POS 5
`define CONV_MUX_CHAN_POS 0

`define CONV_CS_ENABLE_POS 7
`define CONV_CS_START_POS 6
`define CONV_CS_AUTO_POS 5
`define CONV_CS_FLAG_POS 4
`define CONV_CS_IE_POS 3
`define CONV_CS_PRESC_POS 0

`define CONV_SF_TRIG_POS 5

`define CONV_MUX_RESET 8'h00
`define CONV_CTRL_RESET 8'h00
`define CONV_SPECIAL_RESET 3'h0

`define CONV_NORMAL_TICKS 5'h0d
`define CONV_FIRST_TICKS 5'h19

`define CONV_SRC_FREE_RUN 3'h0
`define CONV_CHAN_BANDGAP 5'h1e
`define CONV_CHAN_GROUND 5'h1f
`define CONV_CHAN_SINGLE_LAST 5'h07

`define CONV_RESP_OKAY 2'h0
`define CONV_RESP_SLVERR 2'h2

`endif

// ---- conv_core_model.sv ----
// far-side converter core model: hands out result codes and counts converter ticks
module conv_core_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic converting_i,
   input wire logic tick_i,
   input wire logic done_i,
   input wire logic [9:0] code_i,
   output logic [9:0] core_result_o,
   output logic [7:0] ticks_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] junk_reg;
   logic [7:0] cnt_reg;

   // outside a conversion the code wanders, so a sample taken at the wrong moment shows up
   assign core_result_o = (converting_i || done_i) ? code_i : junk_reg;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         junk_reg <= 10'h155;
      else
         junk_reg <= ~junk_reg + 10'h13b;
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         cnt_reg <= 8'h00;
         ticks_o <= 8'h00;
      end
      else if (done_i)
      begin
         ticks_o <= cnt_reg + {7'h0, tick_i};
         cnt_reg <= 8'h00;
      end
      else if (converting_i && tick_i)
         cnt_reg <= cnt_reg + 8'h01;
      else if (!converting_i)
         cnt_reg <= 8'h00;
   end
endmodule

// ---- conv_ctrl.sv ----
// conversion controller: register file, start and trigger logic, result interlock
`include "conv_consts.svh"

// Operation
// - result is a 10-bit code, zero at ground
// - reference field picks supply, internal, or none
// - channel field picks input and gain
// - differential pairs use gain, single-ended bypass
// - reference and channel reach analog path only when enabled; gain bypass follows the channel always
// - result right-aligned, left-aligned when bit set
// - low read blocks updates, high read releases
// - blocked completion leaves result unchanged, discarded
// - completion flag set even when result discarded
// - start bit begins conversion, clears when done; stays set while free-running
// - channel change waits for running conversion
// - auto-trigger enable uses selected trigger source
// - trigger edge restarts prescaler and starts conversion
// - held level or edge while busy ignored
// - peripheral flag triggers even with interrupts off
// - own completion flag as source free-runs
// - free-run needs first start, then continues
// - start bit still works with auto-trigger
// - start bit reads one during any conversion
// - completion writes result, sets flag, clears start; free-run keeps start set
// - 13 converter clocks, 25 for first
// - prescaler runs only while enabled
module conv_ctrl #(
   parameter int TRIG_W = 7
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [TRIG_W-1:0] trigger_i,
   input wire logic [9:0] core_result_i,
   output logic converter_enable_o,
   output logic [1:0] reference_select_o,
   output logic [4:0] channel_gain_select_o,
   output logic gain_bypass_o,
   output logic converter_tick_o,
   output logic converting_o,
   output logic first_conversion_o,
   output logic conversion_done_o,
   output logic irq_o
);

   generate
      if (TRIG_W < 1 || TRIG_W > 7)
      begin : g_bad_trig_w
         $error("TRIG_W must lie between 1 and 7");
      end
   endgenerate

   conv_pkg::analog_sel_s sel_reg;
   conv_pkg::analog_sel_s active_sel_reg;
   conv_pkg::ctrl_s ctrl_reg;
   logic [2:0] trig_src_reg;
   logic flag_reg;
   logic busy_reg;
   logic pend_reg;
   logic long_reg;
   logic first_reg;
   logic [4:0] tick_cnt_reg;
   logic [9:0] result_reg;
   logic lock_reg;

   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic wr_go;
   logic rd_go;
   logic [7:0] rd_byte;
   logic rd_hit;

   logic tick;
   logic [TRIG_W-1:0] trig_rise;
   logic trig_edge;
   logic trig_start;
   logic sw_start;
   logic done;
   logic free_run;
   logic begin_conv;
   logic [4:0] conv_len;
   logic enable_write;

   conv_trig_sync #(.W(TRIG_W)) u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .async_i(trigger_i),
      .rise_o(trig_rise)
   );

   conv_prescaler u_presc (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .run_i(ctrl_reg.converter_enable),
      .restart_i(trig_start),
      .div_sel_i(ctrl_reg.prescale_select),
      .tick_o(tick)
   );

   // bus slave: address and data may come in either order, one write at a time
   assign s_axi_awready_o = !aw_full_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_full_reg && !s_axi_bvalid_o;
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign rd_go = s_axi_arvalid_i && s_axi_arready_o;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
         end
         else if (wr_go)
            aw_full_reg <= 1'b0;
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i[7:0];
            w_strb_reg <= s_axi_wstrb_i[0];
         end
         else if (wr_go)
            w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `CONV_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid_o <= 1'b1;
         if (aw_addr_reg == `CONV_OFS_MUX_SEL || aw_addr_reg == `CONV_OFS_CTRL_STAT ||
             aw_addr_reg == `CONV_OFS_SPECIAL || aw_addr_reg == `CONV_OFS_RES_LOW ||
             aw_addr_reg == `CONV_OFS_RES_HIGH)
            s_axi_bresp_o <= `CONV_RESP_OKAY;
         else
            s_axi_bresp_o <= `CONV_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // register writes; only the low byte lane carries register bits
   assign enable_write = wr_go && w_strb_reg && aw_addr_reg == `CONV_OFS_CTRL_STAT;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         sel_reg <= `CONV_MUX_RESET;
         ctrl_reg <= '0;
         trig_src_reg <= `CONV_SPECIAL_RESET;
      end
      else if (wr_go && w_strb_reg)
      begin
         if (aw_addr_reg == `CONV_OFS_MUX_SEL)
            sel_reg <= w_data_reg;
         else if (aw_addr_reg == `CONV_OFS_CTRL_STAT)
         begin
            ctrl_reg.converter_enable <= w_data_reg[`CONV_CS_ENABLE_POS];
            ctrl_reg.auto_trigger_enable <= w_data_reg[`CONV_CS_AUTO_POS];
            ctrl_reg.complete_irq_enable <= w_data_reg[`CONV_CS_IE_POS];
            ctrl_reg.prescale_select <= w_data_reg[`CONV_CS_PRESC_POS +: 3];
         end
         else if (aw_addr_reg == `CONV_OFS_SPECIAL)
            trig_src_reg <= w_data_reg[`CONV_SF_TRIG_POS +: 3];
      end
   end

   // start and trigger decisions
   assign sw_start = enable_write && w_data_reg[`CONV_CS_START_POS] && w_data_reg[`CONV_CS_ENABLE_POS];
   assign trig_edge = trig_src_reg != `CONV_SRC_FREE_RUN && trig_src_reg <= 3'(TRIG_W) &&
                      trig_rise[trig_src_reg - 3'h1];
   // edges are only looked at while idle, so a held level or a mid-conversion edge does nothing
   assign trig_start = ctrl_reg.converter_enable && ctrl_reg.auto_trigger_enable && trig_edge &&
                       !busy_reg && !pend_reg;
   assign free_run = ctrl_reg.auto_trigger_enable && trig_src_reg == `CONV_SRC_FREE_RUN;
   assign conv_len = long_reg ? `CONV_FIRST_TICKS : `CONV_NORMAL_TICKS;
   assign done = busy_reg && tick && tick_cnt_reg == conv_len - 5'h01;
   assign begin_conv = pend_reg && tick && !busy_reg;

   // conversion sequencer: a request waits for the next converter clock tick
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i || !ctrl_reg.converter_enable)
      begin
         pend_reg <= 1'b0;
         busy_reg <= 1'b0;
         tick_cnt_reg <= 5'h00;
         long_reg <= 1'b0;
      end
      else
      begin
         if (begin_conv)
         begin
            pend_reg <= 1'b0;
            busy_reg <= 1'b1;
            tick_cnt_reg <= 5'h00;
            long_reg <= first_reg;
         end
         else if (sw_start || trig_start)
            pend_reg <= !busy_reg;
         if (done)
         begin
            busy_reg <= ctrl_reg.converter_enable && free_run;
            tick_cnt_reg <= 5'h00;
            long_reg <= 1'b0;
         end
         else if (busy_reg && tick)
            tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
   end

   // the first conversion after switching on gets the long initialisation length
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i || !ctrl_reg.converter_enable)
         first_reg <= 1'b1;
      else if (begin_conv)
         first_reg <= 1'b0;
   end

   // selections are shadowed; they only move between conversions
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         active_sel_reg <= `CONV_MUX_RESET;
      else if (!busy_reg || done)
         active_sel_reg <= sel_reg;
   end

   // completion flag, set beats a clearing write
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         flag_reg <= 1'b0;
      else if (done)
         flag_reg <= 1'b1;
      else if (enable_write && w_data_reg[`CONV_CS_FLAG_POS])
         flag_reg <= 1'b0;
   end

   // result interlock between the low and high byte reads
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         lock_reg <= 1'b0;
      else if (rd_go && s_axi_araddr_i == `CONV_OFS_RES_LOW)
         lock_reg <= 1'b1;
      else if (rd_go && s_axi_araddr_i == `CONV_OFS_RES_HIGH)
         lock_reg <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         result_reg <= 10'h000;
      else if (done && !lock_reg)
         result_reg <= core_result_i;
   end

   // read path; alignment is applied on the way out so a late change of the bit still shows
   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (s_axi_araddr_i == `CONV_OFS_MUX_SEL)
         rd_byte = sel_reg;
      else if (s_axi_araddr_i == `CONV_OFS_CTRL_STAT)
      begin
         rd_byte[`CONV_CS_ENABLE_POS] = ctrl_reg.converter_enable;
         rd_byte[`CONV_CS_START_POS] = busy_reg || pend_reg;
         rd_byte[`CONV_CS_AUTO_POS] = ctrl_reg.auto_trigger_enable;
         rd_byte[`CONV_CS_FLAG_POS] = flag_reg;
         rd_byte[`CONV_CS_IE_POS] = ctrl_reg.complete_irq_enable;
         rd_byte[`CONV_CS_PRESC_POS +: 3] = ctrl_reg.prescale_select;
      end
      else if (s_axi_araddr_i == `CONV_OFS_RES_LOW)
         rd_byte = sel_reg.left_adjust_result ? {result_reg[1:0], 6'h00} : result_reg[7:0];
      else if (s_axi_araddr_i == `CONV_OFS_RES_HIGH)
         rd_byte = sel_reg.left_adjust_result ? result_reg[9:2] : {6'h00, result_reg[9:8]};
      else if (s_axi_araddr_i == `CONV_OFS_SPECIAL)
         rd_byte[`CONV_SF_TRIG_POS +: 3] = trig_src_reg;
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= `CONV_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= {24'h000000, rd_byte};
         s_axi_rresp_o <= rd_hit ? `CONV_RESP_OKAY : `CONV_RESP_SLVERR;
      end
      else if (s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // reference and channel outputs stay parked until the converter is switched on; gain_bypass_o is not gated by the enable
   assign converter_enable_o = ctrl_reg.converter_enable;
   assign reference_select_o = ctrl_reg.converter_enable ? active_sel_reg.reference_select : 2'h0;
   assign channel_gain_select_o = ctrl_reg.converter_enable ? active_sel_reg.channel_gain_select : 5'h00;
   assign gain_bypass_o = active_sel_reg.channel_gain_select <= `CONV_CHAN_SINGLE_LAST ||
                          active_sel_reg.channel_gain_select == `CONV_CHAN_BANDGAP ||
                          active_sel_reg.channel_gain_select == `CONV_CHAN_GROUND;
   assign converter_tick_o = tick;
   assign converting_o = busy_reg;
   assign first_conversion_o = long_reg;
   assign conversion_done_o = done;
   assign irq_o = flag_reg && ctrl_reg.complete_irq_enable;

   // checking helper: converter ticks seen since the conversion began
   logic [4:0] chk_ticks_reg;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i || begin_conv || done)
         chk_ticks_reg <= 5'h00;
      else if (busy_reg && tick)
         chk_ticks_reg <= chk_ticks_reg + 5'h01;
   end

   property p_prescaler_held;
      @(posedge clk_i) disable iff (!resetn_i)
      !ctrl_reg.converter_enable |=> !tick;
   endproperty
   a_prescaler_held: assert property (p_prescaler_held) else $error("tick while disabled");

   property p_single_clears_start;
      @(posedge clk_i) disable iff (!resetn_i)
      done && !free_run |=> !busy_reg && !pend_reg;
   endproperty
   a_single_clears_start: assert property (p_single_clears_start) else $error("start bit not cleared");

   property p_blocked_result;
      @(posedge clk_i) disable iff (!resetn_i)
      done && lock_reg |=> $stable(result_reg);
   endproperty
   a_blocked_result: assert property (p_blocked_result) else $error("locked result changed");

   property p_flag_on_done;
      @(posedge clk_i) disable iff (!resetn_i)
      done |=> flag_reg;
   endproperty
   a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set at completion");

   property p_low_read_locks;
      @(posedge clk_i) disable iff (!resetn_i)
      rd_go && s_axi_araddr_i == `CONV_OFS_RES_LOW |=> lock_reg && s_axi_rvalid_o;
   endproperty
   a_low_read_locks: assert property (p_low_read_locks) else $error("low read did not lock");

   property p_no_start_while_busy;
      @(posedge clk_i) disable iff (!resetn_i)
      busy_reg && !done |=> !pend_reg;
   endproperty
   a_no_start_while_busy: assert property (p_no_start_while_busy) else $error("request taken while busy");

   property p_length;
      @(posedge clk_i) disable iff (!resetn_i)
      done |-> chk_ticks_reg == (long_reg ? 5'h18 : 5'h0c);
   endproperty
   a_length: assert property (p_length) else $error("wrong conversion length");

   property p_parked;
      @(posedge clk_i) disable iff (!resetn_i)
      !converter_enable_o |-> reference_select_o == 2'h0 && channel_gain_select_o == 5'h00;
   endproperty
   a_parked: assert property (p_parked) else $error("selection applied while disabled");

   property p_free_run;
      @(posedge clk_i) disable iff (!resetn_i)
      done && free_run && ctrl_reg.converter_enable |=> busy_reg;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run stopped");

   property p_sel_frozen;
      @(posedge clk_i) disable iff (!resetn_i)
      busy_reg && $past(busy_reg) && !$past(done) |-> $stable(active_sel_reg);
   endproperty
   a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved mid conversion");

endmodule

// ---- conv_pkg.sv ----
// types shared by the conversion controller
package conv_pkg;

   typedef struct packed
   {
      logic [1:0] reference_select;
      logic left_adjust_result;
      logic [4:0] channel_gain_select;
   } analog_sel_s;

   typedef struct packed
   {
      logic converter_enable;
      logic auto_trigger_enable;
      logic complete_irq_enable;
      logic [2:0] prescale_select;
   } ctrl_s;

endpackage

// ---- conv_prescaler.sv ----
// converter clock prescaler: one tick every 2..256 system clocks
module conv_prescaler (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic run_i,
   input wire logic restart_i,
   input wire logic [2:0] div_sel_i,
   output logic tick_o
);

   logic [7:0] count_reg;
   logic [8:0] span;
   logic [7:0] terminal;

   assign span = (9'h002 << div_sel_i) - 9'h001;
   assign terminal = span[7:0];

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i || !run_i || restart_i)
      begin
         count_reg <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (count_reg >= terminal)
      begin
         count_reg <= 8'h00;
         tick_o <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 8'h01;
         tick_o <= 1'b0;
      end
   end

endmodule

// ---- conv_trig_sync.sv ----
// two-flop synchroniser with rising-edge detection for the trigger inputs
module conv_trig_sync #(
   parameter int W = 7
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] rise_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign rise_o = sync_reg & ~prev_reg;

endmodule
